// ---- src/cgm_gain_mute_path.sv ----
// Digital level control between converters and the serial port.
// Assumes frameStrobe is a one-cycle pulse per sample on clk; samples are
// valid with it. Control bits come from registers outside and are synchronous.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Converted sample is a 16-bit two's complement value.
// - A digital gain follows the converter on receive.
// - Receive gain spans +12 dB to -34.5 dB in 1.5 dB steps.
// - Transmit gain spans +12 dB to -34.5 dB in 1.5 dB steps.
// - A new gain waits pending until the sample crosses zero.
// - After 256 frames without crossing, the pending gain applies.
// - Receive gain comes from the ADC volume setting.
// - Transmit gain comes from the DAC volume setting.
// - Microphone pre-gain 0, 10, 20 or 30 dB.
// - Line pre-gain 0, 10 or 20 dB.
// - Microphone pre-gain comes from micGain, line pre-gain from lineGain.
// - Microphone, line and handset are summed into one stream.
// - Each input has a mute bit removing it from the mix.
// - Line, speaker and handset outputs are each muted independently by their own bit.
// - Line out mutes on its bit and follows the analog attenuation.
// - High-pass near 10 Hz unless disabled, then passes to DC.
// - Left and right speakers mute separately.
// - One frame is one sample period for the timeout.
module cgm_gain_mute_path #(
   parameter int TIMEOUT = cgm_pkg::TIMEOUT_FRAMES
) (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              reset,
   // Frame pacing
   input  wire logic                              frameStrobe,
   // Input samples from the three sources
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] micIn,
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] lineIn,
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] handsetIn,
   // Sample from the serial port for playback
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] txSample,
   // Control bits
   input  wire logic [1:0]                        micGain,
   input  wire logic [1:0]                        lineGain,
   input  wire logic                              micMute,
   input  wire logic                              lineInMute,
   input  wire logic                              handsetInMute,
   input  wire logic [cgm_pkg::GAIN_W-1:0]         adcVolume,
   input  wire logic [cgm_pkg::GAIN_W-1:0]         dacVolume,
   input  wire logic                              highpassDisable,
   input  wire logic                              lineOutMute,
   input  wire logic                              speakerLeftMute,
   input  wire logic                              speakerRightMute,
   input  wire logic                              handsetOutMute,
   input  wire logic [cgm_pkg::ATTEN_W-1:0]        analogAtten,
   // Outputs
   output logic signed [cgm_pkg::SAMPLE_W-1:0]    rxSample,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]    lineOut,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]    speakerLeftOut,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]    speakerRightOut,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]    handsetOut,
   output logic [cgm_pkg::GAIN_W-1:0]             rxGainApplied,
   output logic [cgm_pkg::GAIN_W-1:0]             txGainApplied
);
   import cgm_pkg::*;

   typedef struct packed {
      logic signed [ACC_W-1:0]    hpX;
      logic signed [ACC_W-1:0]    hpY;
      logic signed [SAMPLE_W-1:0] rxLast;
      logic signed [SAMPLE_W-1:0] txLast;
      logic [GAIN_W-1:0]          rxGain;
      logic [GAIN_W-1:0]          txGain;
      logic [TOUT_W-1:0]          rxCount;
      logic [TOUT_W-1:0]          txCount;
      logic signed [SAMPLE_W-1:0] rxOut;
      logic signed [SAMPLE_W-1:0] line_out;
      logic signed [SAMPLE_W-1:0] spkL;
      logic signed [SAMPLE_W-1:0] spkR;
      logic signed [SAMPLE_W-1:0] hsO;
   } cgm_state_type;

   cgm_state_type state_q;
   cgm_state_type state_d;

   //////////////////////////////////////////////////////////////////////////
   // Gain in Q4.12 for code c: 4.0 times 10^(-1.5 c / 20).
   function automatic logic [COEF_W-1:0] cgm_gain_coef(input logic [GAIN_W-1:0] c);
      logic [COEF_W-1:0] base;
      logic [COEF_W-1:0] t;
      base = 16'h0000;
      unique case (c[1:0])
         // Code 0 is rounded to exactly 4.0 so that code 8 is an exact unity gain.
         2'h0: base = 16'h4000;
         2'h1: base = 16'h35C6;
         2'h2: base = 16'h2D6B;
         2'h3: base = 16'h2666;
      endcase
      // Every four steps is -6 dB, a halving.
      t = base >> c[4:2];
      return t;
   endfunction : cgm_gain_coef

   // Saturating scale by a Q4.12 factor.
   function automatic logic signed [SAMPLE_W-1:0] cgm_scale(
      input logic signed [ACC_W-1:0] x, input logic [COEF_W-1:0] k);
      logic signed [ACC_W+COEF_W:0] p;
      logic signed [ACC_W+COEF_W:0] s;
      p = x * $signed({1'b0, k});
      s = p >>> COEF_FRAC;
      if (s > 32767)
         return 16'sh7FFF;
      else if (s < -32768)
         return 16'sh8000;
      else
         return s[SAMPLE_W-1:0];
   endfunction : cgm_scale

   function automatic logic cgm_cross(input logic signed [SAMPLE_W-1:0] a,
                                       input logic signed [SAMPLE_W-1:0] b);
      return (b == 16'sh0000) || (a[SAMPLE_W-1] != b[SAMPLE_W-1]);
   endfunction : cgm_cross

   //////////////////////////////////////////////////////////////////////////
   logic signed [ACC_W-1:0]    micAmp;
   logic signed [ACC_W-1:0]    lineAmp;
   logic signed [ACC_W-1:0]    mix;
   logic signed [ACC_W-1:0]    hpNext;
   logic signed [SAMPLE_W-1:0] adcWord;
   logic signed [SAMPLE_W-1:0] rxScaled;
   logic signed [SAMPLE_W-1:0] txScaled;
   logic signed [SAMPLE_W-1:0] lineAtt;
   logic                       rxPend;
   logic                       txPend;
   logic                       rxCross;
   logic                       txCross;

   always_comb begin
      state_d = state_q;
      // Each pre-gain selection comes from its own control input, micGain or lineGain.
      // Microphone pre-gain, about 3.16x per 10 dB.
      unique case (micGain)
         2'h0: micAmp = ACC_W'(micIn);
         2'h1: micAmp = ACC_W'((ACC_W'(micIn) * 20'sd202) >>> 6);
         2'h2: micAmp = ACC_W'(micIn) * 20'sd10;
         2'h3: micAmp = ACC_W'((ACC_W'(micIn) * 20'sd2023) >>> 6);
      endcase
      // Line pre-gain; the unused fourth code acts as 20 dB.
      unique case (lineGain)
         2'h0: lineAmp = ACC_W'(lineIn);
         2'h1: lineAmp = ACC_W'((ACC_W'(lineIn) * 20'sd202) >>> 6);
         default: lineAmp = ACC_W'(lineIn) * 20'sd10;
      endcase
      // Mono mix. Muted inputs drop out.
      mix = (micMute ? '0 : micAmp) + (lineInMute ? '0 : lineAmp)
          + (handsetInMute ? '0 : ACC_W'(handsetIn));
      // One-pole DC blocker, bypassed when disabled.
      hpNext = ACC_W'(mix - ACC_W'(state_q.hpX) + state_q.hpY
             - (state_q.hpY >>> HP_SHIFT));
      // Converter word is 16-bit signed, clipped at full scale.
      adcWord = cgm_scale(highpassDisable ? mix : hpNext, 16'h1000);
      rxScaled = cgm_scale(ACC_W'(adcWord), cgm_gain_coef(state_q.rxGain));
      txScaled = cgm_scale(ACC_W'(txSample), cgm_gain_coef(state_q.txGain));
      // Analog attenuation modelled as 6 dB-ish halvings per 4 codes.
      lineAtt = txScaled >>> analogAtten[3:2];
      // Pending when the setting differs from the applied.
      rxPend = adcVolume != state_q.rxGain;
      txPend = dacVolume != state_q.txGain;
      rxCross = cgm_cross(state_q.rxLast, adcWord);
      txCross = cgm_cross(state_q.txLast, txSample);
      if (frameStrobe) begin
         // The filter must remember its own input, not its output, or DC is
         // amplified instead of removed. Its input keeps tracking while bypassed; its output is held at zero.
         state_d.hpX = mix;
         state_d.hpY = highpassDisable ? '0 : hpNext;
         state_d.rxLast = adcWord;
         state_d.txLast = txSample;
         // Apply on crossing or frame timeout.
         if (rxPend && (rxCross || state_q.rxCount == TOUT_W'(TIMEOUT - 1))) begin
            state_d.rxGain = adcVolume;
            state_d.rxCount = '0;
         end else if (rxPend)
            state_d.rxCount = state_q.rxCount + 1'b1;
         else
            state_d.rxCount = '0;
         if (txPend && (txCross || state_q.txCount == TOUT_W'(TIMEOUT - 1))) begin
            state_d.txGain = dacVolume;
            state_d.txCount = '0;
         end else if (txPend)
            state_d.txCount = state_q.txCount + 1'b1;
         else
            state_d.txCount = '0;
         state_d.rxOut = rxScaled;
         state_d.line_out = lineOutMute ? '0 : lineAtt;
         state_d.spkL = speakerLeftMute ? '0 : txScaled;
         state_d.spkR = speakerRightMute ? '0 : txScaled;
         state_d.hsO = handsetOutMute ? '0 : txScaled;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= '0;
         state_q.rxGain <= GAIN_RESET;
         state_q.txGain <= GAIN_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign rxSample        = state_q.rxOut;
   assign lineOut         = state_q.line_out;
   assign speakerLeftOut  = state_q.spkL;
   assign speakerRightOut = state_q.spkR;
   assign handsetOut      = state_q.hsO;
   assign rxGainApplied   = state_q.rxGain;
   assign txGainApplied   = state_q.txGain;

   //////////////////////////////////////////////////////////////////////////
   // Pending gain never waits past the timeout.
   a_rx_timeout_bound: assert property (@(posedge clk) disable iff (reset)
      state_q.rxCount < TOUT_W'(TIMEOUT)) else $error("rx gain timeout overrun");
   a_tx_timeout_bound: assert property (@(posedge clk) disable iff (reset)
      state_q.txCount < TOUT_W'(TIMEOUT)) else $error("tx gain timeout overrun");
   a_rx_gain_cross: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && rxPend && !rxCross && state_q.rxCount != TOUT_W'(TIMEOUT - 1)
      |=> $stable(rxGainApplied)) else $error("rx gain changed without crossing");
   a_tx_gain_cross: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && txPend && txCross |=> txGainApplied == $past(dacVolume))
      else $error("tx gain not applied on crossing");
   a_line_mute: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && lineOutMute |=> lineOut == 16'sh0000) else $error("line not muted");
   a_spk_left_mute: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && speakerLeftMute |=> speakerLeftOut == 16'sh0000)
      else $error("left speaker not muted");
   a_spk_right_mute: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && speakerRightMute |=> speakerRightOut == 16'sh0000)
      else $error("right speaker not muted");
   a_hs_out_mute: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && handsetOutMute |=> handsetOut == 16'sh0000)
      else $error("handset out not muted");
   a_mix_all_muted: assert property (@(posedge clk) disable iff (reset)
      micMute && lineInMute && handsetInMute |-> mix == '0) else $error("mix not silent");
   a_gain_unity_pass: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && state_q.txGain == GAIN_RESET && !speakerLeftMute
      |=> speakerLeftOut == $past(txSample)) else $error("0 dB not unity");

   //////////////////////////////////////////////////////////////////////////
   // Gain application, counters and output paths checked frame by frame.
   a_rx_gain_apply: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && rxPend && rxCross |=> rxGainApplied == $past(adcVolume))
      else $error("rx gain not applied on crossing");
   a_tx_gain_hold: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && txPend && !txCross && state_q.txCount != TOUT_W'(TIMEOUT - 1)
      |=> $stable(txGainApplied)) else $error("tx gain changed without crossing");
   a_rx_timeout_apply: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && rxPend && state_q.rxCount == TOUT_W'(TIMEOUT - 1)
      |=> rxGainApplied == $past(adcVolume)) else $error("rx gain not forced");
   a_tx_timeout_apply: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && txPend && state_q.txCount == TOUT_W'(TIMEOUT - 1)
      |=> txGainApplied == $past(dacVolume)) else $error("tx gain not forced");
   a_rx_count_clear: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && !rxPend |=> state_q.rxCount == '0) else $error("rx count kept");
   a_tx_count_clear: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && !txPend |=> state_q.txCount == '0) else $error("tx count kept");
   a_gain_idle_hold: assert property (@(posedge clk) disable iff (reset)
      !frameStrobe |=> $stable(rxGainApplied) && $stable(txGainApplied))
      else $error("gain changed between frames");
   a_count_idle_hold: assert property (@(posedge clk) disable iff (reset)
      !frameStrobe |=> $stable(state_q.rxCount) && $stable(state_q.txCount))
      else $error("timeout counted between frames");
   a_out_idle_hold: assert property (@(posedge clk) disable iff (reset)
      !frameStrobe |=> $stable(rxSample) && $stable(speakerLeftOut))
      else $error("sample changed between frames");
   a_rx_zero_cross: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && rxPend && adcWord == 16'sh0000 |=> rxGainApplied == $past(adcVolume))
      else $error("rx zero sample not a crossing");
   a_tx_zero_cross: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && txPend && txSample == 16'sh0000 |=> txGainApplied == $past(dacVolume))
      else $error("tx zero sample not a crossing");
   a_reset_gains: assert property (@(posedge clk)
      reset |=> rxGainApplied == GAIN_RESET && txGainApplied == GAIN_RESET)
      else $error("gain not at reset value");
   a_spk_pair_equal: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && !speakerLeftMute && !speakerRightMute
      |=> speakerLeftOut == speakerRightOut) else $error("speaker pair differs");
   a_hs_out_path: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && !handsetOutMute && !speakerLeftMute
      |=> handsetOut == speakerLeftOut) else $error("handset out differs");
   a_line_out_path: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && !lineOutMute && !speakerRightMute && analogAtten[3:2] == 2'h0
      |=> lineOut == speakerRightOut) else $error("line out differs");
   a_mix_handset_only: assert property (@(posedge clk) disable iff (reset)
      micMute && lineInMute && !handsetInMute |-> mix == ACC_W'(handsetIn))
      else $error("handset mix wrong");
   a_mix_mic_only: assert property (@(posedge clk) disable iff (reset)
      !micMute && lineInMute && handsetInMute && micGain == 2'h0 |-> mix == ACC_W'(micIn))
      else $error("mic mix wrong");
   a_hp_bypass: assert property (@(posedge clk) disable iff (reset)
      frameStrobe && highpassDisable |=> state_q.hpY == '0) else $error("filter not bypassed");
endmodule : cgm_gain_mute_path

// ---- src/cgm_pkg.sv ----
// Package for the codec gain and mute path: field widths, codes and counts.
// Assumes one 100 MHz clock and samples paced by a one-cycle frame strobe.
package cgm_pkg;
   localparam int          SAMPLE_W        = 16;
   localparam int          GAIN_W          = 5;
   // Gain codes: 0 is +12 dB, each step is 1.5 dB less, 31 is -34.5 dB.
   localparam logic [4:0]  GAIN_CODE_MAX   = 5'h1F;
   localparam logic [4:0]  GAIN_RESET      = 5'h08;
   localparam int          TIMEOUT_FRAMES  = 256;
   localparam int          TOUT_W          = 9;
   localparam int          COEF_W          = 16;
   localparam int          COEF_FRAC       = 12;
   // Pre-amplifier codes.
   localparam logic [1:0]  MIC_GAIN_RESET  = 2'h0;
   localparam logic [1:0]  LINE_GAIN_RESET = 2'h0;
   localparam logic [1:0]  LINE_GAIN_MAX   = 2'h2;
   localparam int          ATTEN_W         = 4;
   // High-pass pole: y = x - x1 + y1 - y1/2^HP_SHIFT, near 10 Hz at 8 kHz.
   localparam int          HP_SHIFT        = 7;
   localparam int          ACC_W           = 20;
endpackage : cgm_pkg

// ---- tb/cgm_dsp_model.sv ----
// DSP side model: offers playback words in frames and keeps the last receive word.
// Assumes frames are paced by a one-cycle frameStrobe on clk.
`timescale 1ns/1ps
module cgm_dsp_model (
   // Clock and pacing
   input  wire logic                           clk,
   input  wire logic                           frameStrobe,
   // Sample exchange
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] txNext,
   input  wire logic signed [cgm_pkg::SAMPLE_W-1:0] rxSample,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]      txSample,
   output logic signed [cgm_pkg::SAMPLE_W-1:0]      rxLast
);
   import cgm_pkg::*;
   // word held in frame.
   // Outside a frame the word is inverted, so a stale sample can never pass as valid.
   assign txSample = frameStrobe ? txNext : ~txNext;
   always_ff @(posedge clk) rxLast <= rxSample;
endmodule : cgm_dsp_model

// ---- tb/tb_top.sv ----
// Bench for the gain and mute path: each test task drives frames and judges the outputs.
// Assumes the package and the DSP side model are compiled ahead of it.
`timescale 1ns/1ps
module tb_top;
   import cgm_pkg::*;
   localparam int TOUT = 4;
   logic               clk = 1'h0, reset = 1'h1, frameStrobe = 1'h0, highpassDisable = 1'h1;
   logic signed [15:0] micIn = 16'h0, lineIn = 16'h0, handsetIn = 16'h0, txNext = 16'h0;
   logic signed [15:0] txSample, rxSample, lineOut, speakerLeftOut, speakerRightOut;
   logic signed [15:0] handsetOut, rxLast;
   logic [1:0]         micGain = 2'h0, lineGain = 2'h0;
   logic               micMute = 1'h0, lineInMute = 1'h0, handsetInMute = 1'h0;
   logic               lineOutMute = 1'h0, speakerLeftMute = 1'h0, speakerRightMute = 1'h0;
   logic               handsetOutMute = 1'h0;
   logic [4:0]         adcVolume = GAIN_RESET, dacVolume = GAIN_RESET;
   logic [4:0]         rxGainApplied, txGainApplied;
   logic [3:0]         analogAtten = 4'h0;
   int                 errTotal = 0, samplesChecked = 0;
   cgm_gain_mute_path #(.TIMEOUT(TOUT)) DUT (.*);
   cgm_dsp_model DSP (.*);
   task automatic checkEq(string what, logic signed [31:0] exp, logic signed [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask : checkEq
   task automatic checkNear(string what, real exp, logic signed [31:0] got);
      samplesChecked++;
      if ($isunknown(got) || (got - exp) ** 2 > (0.03 * exp) ** 2 + 9.0) begin
         errTotal++;
         $display("wrong value %s expected %0.1f seen %0d", what, exp, got);
      end
   endtask : checkNear
   task automatic frame(logic signed [15:0] m, logic signed [15:0] t);
      @(negedge clk);
      micIn = m;
      txNext = t;
      frameStrobe = 1'h1;
      @(negedge clk);
      frameStrobe = 1'h0;
      repeat (2) @(negedge clk);
   endtask : frame
   task automatic test_done();
      $display("checked %0d errors %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task automatic t_outMute();
      logic [3:0] m;
      checkEq("reset gain", 8, rxGainApplied);
      for (int i = 0; i < 4; i++) begin
         m = 4'h8 >> i;
         {lineOutMute, speakerLeftMute, speakerRightMute, handsetOutMute} = m;
         frame(16'h0, 16'h03E8);
         checkEq("line out", m[3] ? 0 : 1000, lineOut);
         checkEq("left out", m[2] ? 0 : 1000, speakerLeftOut);
         checkEq("right out", m[1] ? 0 : 1000, speakerRightOut);
         checkEq("handset out", m[0] ? 0 : 1000, handsetOut);
      end
      analogAtten = 4'h4;
      frame(16'h0, 16'h03E8);
      checkEq("line atten", 500, lineOut);
      analogAtten = 4'h0;
   endtask : t_outMute
   task automatic t_mix();
      logic [2:0] m;
      real e;
      lineIn = 16'h00C8;
      handsetIn = 16'hFD44;
      for (int i = 0; i < 4; i++) begin
         m = 3'(4'h8 >> i);
         {micMute, lineInMute, handsetInMute} = m;
         micGain = 2'(i);
         lineGain = 2'(i);
         frame(16'h0064, 16'h0);
         e = (m[2] ? 0.0 : 100.0 * 10.0 ** (i / 2.0)) - (m[0] ? 0.0 : 700.0);
         e = e + (m[1] ? 0.0 : 200.0 * 10.0 ** ((i > 2 ? 2 : i) / 2.0));
         checkNear("mix level", e, rxLast);
      end
      {micMute, lineInMute, handsetInMute} = 3'h7;
      frame(16'h0064, 16'h0);
      checkEq("all muted", 0, rxLast);
      micGain = 2'h0;
      lineIn = 16'h0;
      handsetIn = 16'h0;
      {micMute, lineInMute, handsetInMute} = 3'h0;
      highpassDisable = 1'h0;
      repeat (300) frame(16'h03E8, 16'h0);
      checkEq("dc blocked", 1, rxLast < 300);
      highpassDisable = 1'h1;
   endtask : t_mix
   task automatic t_timeout();
      frame(16'h01F4, 16'h01F4);
      dacVolume = 5'h0A;
      repeat (TOUT - 2) frame(16'h01F4, 16'h01F4);
      checkEq("tx held", 8, txGainApplied);
      repeat (3) frame(16'h01F4, 16'h01F4);
      checkEq("tx forced", 10, txGainApplied);
      adcVolume = 5'h0C;
      frame(16'h01F4, 16'h01F4);
      checkEq("rx pending", 8, rxGainApplied);
      frame(16'hFE0C, 16'hFE0C);
      checkEq("rx crossed", 12, rxGainApplied);
   endtask : t_timeout
   task automatic t_sweep();
      real e;
      for (int c = 31; c >= 0; c--) begin
         adcVolume = 5'(c);
         dacVolume = 5'(c);
         frame(16'h0, 16'h0);
         frame(16'h03E8, 16'h03E8);
         e = 1000.0 * 10.0 ** ((12.0 - 1.5 * c) / 20.0);
         checkNear("rx level", e, rxLast);
         checkNear("tx level", e, speakerRightOut);
         checkEq("rx code", c, rxGainApplied);
         checkEq("tx code", c, txGainApplied);
      end
      frame(16'h4E20, 16'hB1E0);
      checkEq("rx clip", 32767, rxLast);
      checkEq("tx clip", -32768, speakerLeftOut);
   endtask : t_sweep
   initial forever #5 clk = ~clk;
   initial begin
      repeat (8) @(negedge clk);
      reset = 1'h0;
      t_outMute();
      t_mix();
      t_timeout();
      t_sweep();
      test_done();
   end
   // A hang counts as a mismatch and still ends in the verdict.
   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      test_done();
   end
endmodule : tb_top
